/* File: sbst_consts.svh */
// constants of the sram boundary-scan test port: widths, opcodes, reset values
// assumes inclusion by bare name from every file that needs them
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH

// register widths
`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_W 16

// instruction opcodes; the three remaining codes are reserved
`define SBST_OP_EXTEST 3'h0
`define SBST_OP_IDCODE 3'h1
`define SBST_OP_SAMPLE_Z 3'h2
`define SBST_OP_SAMPLE 3'h4
`define SBST_OP_BYPASS 3'h7

// value loaded into the instruction shifter in capture-ir (low bits 01)
`define SBST_IR_CAPTURE 3'h1

// level of the test pins when nothing drives them (pulled up)
`define SBST_PULL_LEVEL 1'h1

// bypass value captured in capture-dr
`define SBST_BYPASS_CAPTURE 1'h0

`endif

/* File: sbst_pkg.sv */
// types of the sram boundary-scan test port
// assumes nothing of its surroundings
package sbst_pkg;

	typedef enum logic [3:0] {
		SBST_EXIT2_DR = 4'h0,
		SBST_EXIT1_DR = 4'h1,
		SBST_SHIFT_DR = 4'h2,
		SBST_PAUSE_DR = 4'h3,
		SBST_SEL_IR = 4'h4,
		SBST_UPDATE_DR = 4'h5,
		SBST_CAPTURE_DR = 4'h6,
		SBST_SEL_DR = 4'h7,
		SBST_EXIT2_IR = 4'h8,
		SBST_EXIT1_IR = 4'h9,
		SBST_SHIFT_IR = 4'ha,
		SBST_PAUSE_IR = 4'hb,
		SBST_IDLE = 4'hc,
		SBST_UPDATE_IR = 4'hd,
		SBST_CAPTURE_IR = 4'he,
		SBST_RESET = 4'hf
	} sbst_state_t;

	typedef enum logic [1:0] {
		SBST_PATH_BYPASS = 2'h0,
		SBST_PATH_ID = 2'h1,
		SBST_PATH_BSR = 2'h2
	} sbst_path_t;

endpackage : sbst_pkg

/* File: sbst_sync.sv */
// two-flop synchroniser for a vector of asynchronous pins
// assumes each bit is independent; no bus coherence is given
`timescale 1ns/1ns
`default_nettype none

module sbst_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pins and their synchronised copy
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_q
);

	logic [W-1:0] meta_q;

	// meta_q is read by sync_q only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule : sbst_sync

`default_nettype wire

/* File: sbst_fsm.sv */
// tap controller state register with the sixteen-state sequence
// assumes step is a one-cycle pulse per rising test clock edge
`timescale 1ns/1ns
`default_nettype none

module sbst_fsm import sbst_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// rising test clock edge and sampled mode select
	input wire logic step,
	input wire logic tms,
	// current state
	output sbst_state_t state_q
);

	sbst_state_t state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			SBST_RESET: state_d = tms ? SBST_RESET : SBST_IDLE;
			SBST_IDLE: state_d = tms ? SBST_SEL_DR : SBST_IDLE;
			SBST_SEL_DR: state_d = tms ? SBST_SEL_IR : SBST_CAPTURE_DR;
			SBST_CAPTURE_DR: state_d = tms ? SBST_EXIT1_DR : SBST_SHIFT_DR;
			SBST_SHIFT_DR: state_d = tms ? SBST_EXIT1_DR : SBST_SHIFT_DR;
			SBST_EXIT1_DR: state_d = tms ? SBST_UPDATE_DR : SBST_PAUSE_DR;
			SBST_PAUSE_DR: state_d = tms ? SBST_EXIT2_DR : SBST_PAUSE_DR;
			SBST_EXIT2_DR: state_d = tms ? SBST_UPDATE_DR : SBST_SHIFT_DR;
			SBST_UPDATE_DR: state_d = tms ? SBST_SEL_DR : SBST_IDLE;
			SBST_SEL_IR: state_d = tms ? SBST_RESET : SBST_CAPTURE_IR;
			SBST_CAPTURE_IR: state_d = tms ? SBST_EXIT1_IR : SBST_SHIFT_IR;
			SBST_SHIFT_IR: state_d = tms ? SBST_EXIT1_IR : SBST_SHIFT_IR;
			SBST_EXIT1_IR: state_d = tms ? SBST_UPDATE_IR : SBST_PAUSE_IR;
			SBST_PAUSE_IR: state_d = tms ? SBST_EXIT2_IR : SBST_PAUSE_IR;
			SBST_EXIT2_IR: state_d = tms ? SBST_UPDATE_IR : SBST_SHIFT_IR;
			SBST_UPDATE_IR: state_d = tms ? SBST_SEL_DR : SBST_IDLE;
			default: state_d = SBST_RESET;
		endcase
	end

	// any state reaches reset after five tms-high edges
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= SBST_RESET;
		end else if (step) begin
			state_q <= state_d;
		end
	end

endmodule : sbst_fsm

`default_nettype wire

/* File: sbst_tap.sv */
// top of the sram boundary-scan test port: registers, path select, test data out
// assumes test pins arrive asynchronously and sys_clk runs well above the test clock
`timescale 1ns/1ns
`default_nettype none

`include "sbst_consts.svh"

module sbst_tap import sbst_pkg::*; #(
	// arbitrary identification value, lsb set as usual for such codes
	parameter logic [`SBST_ID_W-1:0] ID_VALUE = 32'h0a5c_3001
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// test pins from the external controller
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	// pin ring observed by the boundary register
	input wire logic [`SBST_BSR_W-1:0] ring_pins,
	// test data out, three-state as output plus enable
	output logic tdo_o,
	output logic tdo_oe,
	// to the memory datapath
	output logic mem_out_hiz_q,
	// status
	output logic [`SBST_IR_W-1:0] instr_q,
	output logic tap_in_reset_q
);

	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic [`SBST_BSR_W-1:0] ring_s;
	logic tck_prev_q;
	logic tck_rise;
	logic tck_fall;
	sbst_state_t state_q;
	logic [`SBST_IR_W-1:0] ir_shift_q;
	logic [`SBST_ID_W-1:0] id_shift_q;
	logic [`SBST_BSR_W-1:0] bsr_q;
	logic bypass_q;
	logic tdo_d;
	logic tdo_q;
	logic tdo_oe_q;
	sbst_path_t path;
	// one strobe for each rising test clock edge that does work, plus in_shift, a level held through the two shift states
	logic cap_ir;
	logic sh_ir;
	logic upd_ir;
	logic cap_dr;
	logic sh_dr;
	logic to_reset;
	logic in_shift;
	wire logic [`SBST_BSR_W-1:0] bsr_d;

	// instruction to data path; reserved codes fall back to bypass
	function automatic sbst_path_t path_of(input logic [`SBST_IR_W-1:0] op);
		sbst_path_t p;
		p = SBST_PATH_BYPASS;
		if (op == `SBST_OP_IDCODE) begin
			p = SBST_PATH_ID;
		end else if (op == `SBST_OP_EXTEST || op == `SBST_OP_SAMPLE_Z) begin
			p = SBST_PATH_BSR;
		end else if (op == `SBST_OP_SAMPLE) begin
			p = SBST_PATH_BSR;
		end
		return p;
	endfunction : path_of

	// instructions that float the memory outputs
	function automatic logic floats_outputs(input logic [`SBST_IR_W-1:0] op);
		return (op == `SBST_OP_EXTEST) || (op == `SBST_OP_SAMPLE_Z);
	endfunction : floats_outputs

	// mode select resets to the pulled-up level so an idle port sits in reset
	sbst_sync #(
		.W(1),
		.RST_VAL(`SBST_PULL_LEVEL)
	) u_sync_tms (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(tms),
		.sync_q(tms_s)
	);

	// data in is pulled up as well
	sbst_sync #(
		.W(1),
		.RST_VAL(`SBST_PULL_LEVEL)
	) u_sync_tdi (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(tdi),
		.sync_q(tdi_s)
	);

	sbst_sync #(
		.W(1),
		.RST_VAL(1'h0)
	) u_sync_tck (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(tck),
		.sync_q(tck_s)
	);

	// ring pins move on the fast memory clock; a value mid-change is not guaranteed
	sbst_sync #(
		.W(`SBST_BSR_W),
		.RST_VAL('0)
	) u_sync_ring (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(ring_pins),
		.sync_q(ring_s)
	);

	// test clock edges found on the synchronised copy
	// both flops reset low like the tied-low idle pin, so reset makes no false edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tck_prev_q <= 1'h0;
		end else begin
			tck_prev_q <= tck_s;
		end
	end

	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;

	// state machine steps only on rising edges
	sbst_fsm u_fsm (
		.sys_clk(sys_clk),
		.rst(rst),
		.step(tck_rise),
		.tms(tms_s),
		.state_q(state_q)
	);

	// only the held instruction picks the data path
	assign path = path_of(instr_q);

	// state decoded once here so every register acts on the same rising edge
	assign cap_ir = tck_rise && (state_q == SBST_CAPTURE_IR);
	assign sh_ir = tck_rise && (state_q == SBST_SHIFT_IR);
	assign upd_ir = tck_rise && (state_q == SBST_UPDATE_IR);
	assign cap_dr = tck_rise && (state_q == SBST_CAPTURE_DR);
	assign sh_dr = tck_rise && (state_q == SBST_SHIFT_DR);

	// driver enable follows the two shift states only
	assign in_shift = (state_q == SBST_SHIFT_IR) || (state_q == SBST_SHIFT_DR);

	// mirrors the state machine's way into reset, so the identification
	// instruction is already held in every cycle the port reports reset
	assign to_reset = tck_rise && ((state_q == SBST_RESET) ||
		((state_q == SBST_SEL_IR) && tms_s));

	// instruction register: shifter and the held instruction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ir_shift_q <= `SBST_IR_CAPTURE;
		end else if (cap_ir || sh_ir) begin
			if (cap_ir) begin
				ir_shift_q <= `SBST_IR_CAPTURE;
			end else begin
				ir_shift_q <= {tdi_s, ir_shift_q[`SBST_IR_W-1:1]};
			end
		end
	end

	// a new instruction only acts once update-ir is left
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			instr_q <= `SBST_OP_IDCODE;
		end else if (to_reset || upd_ir) begin
			if (to_reset) begin
				instr_q <= `SBST_OP_IDCODE;
			end else begin
				instr_q <= ir_shift_q;
			end
		end
	end

	// identification register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			id_shift_q <= '0;
		end else if (path == SBST_PATH_ID) begin
			if (cap_dr) begin
				id_shift_q <= ID_VALUE;
			end else if (sh_dr) begin
				id_shift_q <= {tdi_s, id_shift_q[`SBST_ID_W-1:1]};
			end
		end
	end

	// boundary cells: capture the ring or take the neighbour toward tdi
	for (genvar i = 0; i < `SBST_BSR_W; i++) begin : g_bsr_cell
		if (i == `SBST_BSR_W - 1) begin : g_msb
			assign bsr_d[i] = cap_dr ? ring_s[i] : tdi_s;
		end else begin : g_inner
			assign bsr_d[i] = cap_dr ? ring_s[i] : bsr_q[i + 1];
		end
	end

	// boundary register: capture only; with no preload latch update-dr acts like pause
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bsr_q <= '0;
		end else if ((cap_dr || sh_dr) && path == SBST_PATH_BSR) begin
			bsr_q <= bsr_d;
		end
	end

	// bypass register; capture clears it, so its first bit out is always zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bypass_q <= `SBST_BYPASS_CAPTURE;
		end else if (path == SBST_PATH_BYPASS) begin
			if (cap_dr) begin
				bypass_q <= `SBST_BYPASS_CAPTURE;
			end else if (sh_dr) begin
				bypass_q <= tdi_s;
			end
		end
	end

	// serial output source
	always_comb begin
		tdo_d = bypass_q;
		if (state_q == SBST_SHIFT_IR) begin
			tdo_d = ir_shift_q[0];
		end else begin
			case (path)
				SBST_PATH_ID: tdo_d = id_shift_q[0];
				SBST_PATH_BSR: tdo_d = bsr_q[0];
				default: tdo_d = bypass_q;
			endcase
		end
	end

	// output moves on falling edges so the controller samples a settled bit
	// it lags the pin fall by about three system clocks, well inside a low phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tdo_q <= `SBST_PULL_LEVEL;
		end else if (tck_fall) begin
			tdo_q <= tdo_d;
		end
	end

	// driver on only for bits shifted in either shift state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tdo_oe_q <= 1'h0;
		end else if (tck_fall) begin
			tdo_oe_q <= in_shift;
		end
	end

	assign tdo_o = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// memory outputs float only on explicit request; reset keeps memory usable
	// one clock behind instr_q; the memory itself never stops for the port
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mem_out_hiz_q <= 1'h0;
		end else begin
			mem_out_hiz_q <= floats_outputs(instr_q);
		end
	end

	// status lags the state register by one clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tap_in_reset_q <= 1'h1;
		end else begin
			tap_in_reset_q <= (state_q == SBST_RESET);
		end
	end

endmodule : sbst_tap

`default_nettype wire

/* File: sbst_tap_assertions.sv */
// concurrent checks of the boundary-scan test port, bound to its top
// assumes test pins change only away from rising sys_clk edges
`timescale 1ns/1ns
`default_nettype none
`include "sbst_consts.svh"

module sbst_tap_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// test pins
	input wire logic tck,
	input wire logic tms,
	// outputs watched
	input wire logic tdo_o,
	input wire logic tdo_oe,
	input wire logic mem_out_hiz_q,
	input wire logic [`SBST_IR_W-1:0] instr_q,
	input wire logic tap_in_reset_q
);
	logic tck_q;
	logic [2:0] ones_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// run of rising test clocks with mode select high, saturating at five
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tck_q <= 1'b0;
			ones_q <= 3'h0;
		end else begin
			tck_q <= tck;
			if (tck && !tck_q)
				ones_q <= !tms ? 3'h0 : (ones_q == 3'h5 ? ones_q : ones_q + 3'h1);
		end
	end
	a_oe_at_fall: assert property ($changed(tdo_oe) |-> !$past(tck) && !$past(tck, 3))
		else $error("tdo enable moved outside a low test clock");
	a_tdo_at_fall: assert property (tdo_oe && $changed(tdo_o) |-> !$past(tck, 2))
		else $error("tdo value moved outside a low test clock");
	a_reset_no_drive: assert property (tap_in_reset_q |-> !tdo_oe)
		else $error("tdo driven in reset state");
	a_reset_loads_id: assert property (tap_in_reset_q [*2] |-> instr_q == `SBST_OP_IDCODE)
		else $error("reset state without identification instruction");
	a_five_ones: assert property ($rose(ones_q == 3'h5) |-> ##[1:8] tap_in_reset_q)
		else $error("five high mode selects did not reach reset");
	a_hiz_follows: assert property ($stable(instr_q) |-> mem_out_hiz_q ==
		(instr_q == `SBST_OP_EXTEST || instr_q == `SBST_OP_SAMPLE_Z))
		else $error("memory float flag disagrees with instruction");
	a_instr_on_rise: assert property ($changed(instr_q) |-> $past(tck) && $past(tck, 2))
		else $error("instruction changed away from a rising test clock");
	a_reset_mem_free: assert property (tap_in_reset_q [*2] |-> !mem_out_hiz_q)
		else $error("reset state floats the memory outputs");
endmodule : sbst_tap_chk

bind sbst_tap sbst_tap_chk u_chk (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms),
	.tdo_o(tdo_o), .tdo_oe(tdo_oe), .mem_out_hiz_q(mem_out_hiz_q), .instr_q(instr_q),
	.tap_in_reset_q(tap_in_reset_q));
`default_nettype wire

/* File: sbst_ctl_model.sv */
// external test controller: makes a 160 ns test clock only while stepping
// assumes sys_clk is the 50 MHz bench clock; tck rests high between steps
`timescale 1ns/1ns
`default_nettype none

module sbst_ctl_model (
	// bench clock
	input wire logic sys_clk,
	// test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_o,
	input wire logic tdo_oe
);
	wire logic tdo_w;
	assign tdo_w = tdo_oe ? tdo_o : 1'bz;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one test clock: fall, 5 cycles low, rise, 3 high; q is tdo just before rise
	task automatic step(input logic m, input logic d, output logic q);
		@(negedge sys_clk);
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (5) @(negedge sys_clk);
		q = tdo_w;
		tck = 1'b1;
		repeat (2) @(negedge sys_clk);
	endtask : step
endmodule : sbst_ctl_model
`default_nettype wire

/* File: test_sbst_tap.sv */
// self-checking bench of the boundary-scan test port
// assumes the controller model drives all test pins; sys_clk 20 ns
`timescale 1ns/1ns
`default_nettype none
`include "sbst_consts.svh"

module test_sbst_tap;
	// arbitrary identification value
	localparam logic [31:0] ID_VAL = 32'h0c3a_5e01;
	logic sys_clk;
	logic rst;
	logic [15:0] ring_pins;
	wire logic tck, tms, tdi;
	logic tdo_o, tdo_oe, mem_out_hiz_q, tap_in_reset_q;
	logic [2:0] instr_q;
	logic [2:0] ops [7] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h3, 3'h5, 3'h6};
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;

	sbst_tap #(.ID_VALUE(ID_VAL)) DUT (.sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms),
		.tdi(tdi), .ring_pins(ring_pins), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
		.mem_out_hiz_q(mem_out_hiz_q), .instr_q(instr_q), .tap_in_reset_q(tap_in_reset_q));
	sbst_ctl_model ctl (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
		.tdo_oe(tdo_oe));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// well past the ~3100 cycles the tests need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// idle to shift, n bits lsb first, then update and back to idle
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic q;
		ctl.step(1'b1, 1'b1, q);
		check("tdo in idle", 32'(q), 32'(1'bz));
		if (ir)
			ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			ctl.step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		repeat (3) @(negedge sys_clk);
	endtask : scan

	task automatic t_power_up;
		logic q;
		check("instr", 32'(instr_q), 32'(`SBST_OP_IDCODE));
		check("tdo enable", 32'(tdo_oe), 32'h0);
		check("float", 32'(mem_out_hiz_q), 32'h0);
		check("in reset", 32'(tap_in_reset_q), 32'h1);
		ctl.step(1'b0, 1'b1, q);
		$display("test power_up done");
	endtask : t_power_up

	task automatic t_idcode;
		logic [31:0] d;
		scan(1'b0, 32'h0, 32, d);
		check("id shift", d, ID_VAL);
		$display("test idcode done");
	endtask : t_idcode

	// load op, then shift 32 bits through whichever register it selects
	task automatic t_instr(input logic [2:0] op);
		logic [31:0] d, din, exp;
		logic bsr;
		din = 32'hc3a5_9e17;
		bsr = (op == 3'h0 || op == 3'h2 || op == 3'h4);
		ring_pins = 16'h5a30 | 16'(op);
		scan(1'b1, 32'(op), 3, d);
		check("ir capture", d, 32'h1);
		check("instr", 32'(instr_q), 32'(op));
		check("float", 32'(mem_out_hiz_q), 32'(op == 3'h0 || op == 3'h2));
		exp = bsr ? {din[15:0], ring_pins} : {din[30:0], 1'b0};
		scan(1'b0, din, 32, d);
		check("dr shift", d, exp);
		check("instr after update", 32'(instr_q), 32'(op));
		$display("test instr %h done", op);
	endtask : t_instr

	// five high mode selects from shift-dr, the longest way into reset
	task automatic t_tap_reset;
		logic [31:0] d;
		logic q;
		scan(1'b1, 32'(`SBST_OP_EXTEST), 3, d);
		ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		for (int i = 0; i < 4; i++)
			ctl.step(1'b1, 1'b1, q);
		repeat (4) @(negedge sys_clk);
		check("in reset early", 32'(tap_in_reset_q), 32'h0);
		check("float before reset", 32'(mem_out_hiz_q), 32'h1);
		ctl.step(1'b1, 1'b1, q);
		repeat (4) @(negedge sys_clk);
		check("in reset", 32'(tap_in_reset_q), 32'h1);
		check("instr", 32'(instr_q), 32'(`SBST_OP_IDCODE));
		check("float", 32'(mem_out_hiz_q), 32'h0);
		ctl.step(1'b0, 1'b1, q);
		$display("test tap_reset done");
	endtask : t_tap_reset

	initial begin
		rst = 1'b1;
		ring_pins = 16'h0;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		t_power_up();
		t_idcode();
		foreach (ops[i])
			t_instr(ops[i]);
		t_tap_reset();
		report_and_stop();
	end
endmodule : test_sbst_tap
`default_nettype wire
